// [common/cdus_pkg.sv]
// Shared constants, carriers and helpers for the current DAC update scheduler.
package cdus_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths and field positions.
    localparam int DATA_W       = 10;
    localparam int BYTE_W       = 8;
    localparam int LOW_KEEP_MSB = 7;
    localparam int LOW_KEEP_LSB = 6;
    localparam int TIMER_N      = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // Update source encodings (update_source_select).
    localparam logic [2:0] SRC_TIMER3   = 3'h3;
    localparam logic [2:0] SRC_RISE     = 3'h4;
    localparam logic [2:0] SRC_FALL     = 3'h5;
    localparam logic [2:0] SRC_BOTH     = 3'h6;
    localparam logic [2:0] SRC_ONDEMAND = 3'h7;

    ////////////////////////////////////////////////////////////////////////////////
    // Full-scale codes and one-hot current ranges.
    localparam logic [1:0] FS_CODE_HALF  = 2'h0;
    localparam logic [1:0] FS_CODE_ONE   = 2'h1;
    localparam logic [2:0] FS_HOT_HALF   = 3'h1;
    localparam logic [2:0] FS_HOT_ONE    = 3'h2;
    localparam logic [2:0] FS_HOT_TWO    = 3'h4;
    localparam logic [2:0] FS_HOT_RESET  = 3'h4;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [DATA_W-1:0] WORD_RESET = 10'h000;
    localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;

    // Processor write to the data bytes.
    typedef struct packed {
        logic              we_high;
        logic              we_low;
        logic [BYTE_W-1:0] data;
    } cdus_wr_t;

    // Ownership and drive state of the shared port pin.
    typedef struct packed {
        logic gpio_owned;
        logic drv_off;
        logic pullup_off;
        logic analog_on;
    } cdus_pin_t;

    localparam cdus_pin_t PIN_RESET = 4'h8;

    // Left-justified word: high byte on top, two top bits of the low byte below.
    function automatic logic [DATA_W-1:0] cdus_compose(input logic [BYTE_W-1:0] hi,
                                                       input logic [BYTE_W-1:0] lo);
        cdus_compose = {hi, lo[LOW_KEEP_MSB:LOW_KEEP_LSB]};
    endfunction

    // Full-scale code to one-hot current range; 1x selects the top range.
    function automatic logic [2:0] cdus_fs_decode(input logic [1:0] code);
        case (code)
            FS_CODE_HALF: cdus_fs_decode = FS_HOT_HALF;
            FS_CODE_ONE:  cdus_fs_decode = FS_HOT_ONE;
            default:      cdus_fs_decode = FS_HOT_TWO;
        endcase
    endfunction

endpackage

// [logic/cdus_strobe_sync.sv]
// Three-stage synchroniser and filtered edge detector for the convert strobe pin.
module cdus_strobe_sync (
    // Clock and reset.
    input  logic ref_clk,
    input  logic rst_n,
    // Asynchronous pin.
    input  logic pin,
    // Registered one-cycle edge pulses.
    output logic rise_q,
    output logic fall_q
);
    logic       s1_q;
    logic       s2_q;
    logic       s3_q;
    logic [2:0] fill_q;
    logic       level_q;
    logic       primed_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Stage one feeds stage two only, to keep metastability contained.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Marks which stages hold real pin samples rather than reset zeros, so the
    // reset value of the chain is never mistaken for the pin's level.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fill_q <= 3'h0;
        end else begin
            fill_q <= {fill_q[1:0], 1'b1};
        end
    end

    // A level counts only once stages two and three agree; the first agreement
    // of real samples primes the level without an edge, so an idle-high pin is quiet.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            level_q  <= 1'b0;
            primed_q <= 1'b0;
            rise_q   <= 1'b0;
            fall_q   <= 1'b0;
        end else begin
            rise_q <= 1'b0;
            fall_q <= 1'b0;
            if (fill_q[2] && (s2_q == s3_q)) begin
                primed_q <= 1'b1;
                level_q  <= s3_q;
                if (primed_q && (s3_q != level_q)) begin
                    rise_q <= s3_q;
                    fall_q <= ~s3_q;
                end
            end
        end
    end
endmodule

// [logic/cdus_update_scheduler.sv]
// Update scheduler for a 10-bit current-output DAC with held data bytes.
// Behaviour
// - Latched 10-bit word alone sets output current.
// - Three full-scale ranges: 0.5, 1, 2 mA.
// - Disabled: pin stays GPIO, DAC disconnected.
// - Enabled: driver, pull-up off; DAC connected.
// - Bias generator runs whenever DAC enabled.
// - Mode 111: high-byte write updates latches.
// - On-demand: low-byte write held until high write.
// - Modes 000-011: hold until timer 0-3 overflow.
// - Trigger copies both bytes together into latches.
// - Modes 100/101/110: strobe rise, fall, both edges.
// - Word left-justified: high[7:0], low[7:6].
// - Full-scale 00/01/1x; 2 mA after reset.
module cdus_update_scheduler (
    // Clock and reset.
    input  logic                             ref_clk,
    input  logic                             rst_n,
    // Control bits.
    input  logic                             dac_enable,
    input  logic [2:0]                       update_source_select,
    input  logic [1:0]                       full_scale_select,
    // Data byte writes.
    input  cdus_pkg::cdus_wr_t               wr,
    // Trigger sources.
    input  logic [cdus_pkg::TIMER_N-1:0]     timer_ovf,
    input  logic                             external_convert_strobe,
    // Converter side.
    output logic [cdus_pkg::DATA_W-1:0]      dac_word_q,
    output logic [2:0]                       fs_range_q,
    output logic                             bias_en_q,
    // Shared pin control.
    output cdus_pkg::cdus_pin_t              pin_q
);
    import cdus_pkg::*;

    logic [BYTE_W-1:0]  high_q;
    logic [BYTE_W-1:0]  low_q;
    logic [TIMER_N-1:0] tmr_prev_q;
    logic [TIMER_N-1:0] tmr_rise;
    logic               strb_rise;
    logic               strb_fall;
    logic               fire;
    logic               demand;

    ////////////////////////////////////////////////////////////////////////////////
    // Strobe pin synchroniser.
    cdus_strobe_sync u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .pin     (external_convert_strobe),
        .rise_q  (strb_rise),
        .fall_q  (strb_fall)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Data holding registers; they never drive the output directly.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            high_q <= BYTE_RESET;
            low_q  <= BYTE_RESET;
        end else begin
            if (wr.we_high) begin
                high_q <= wr.data;
            end
            if (wr.we_low) begin
                low_q <= wr.data;
            end
        end
    end

    // Timer overflows share our clock, so no synchroniser; an overflow held
    // high for several cycles still counts once.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tmr_prev_q <= '0;
        end else begin
            tmr_prev_q <= timer_ovf;
        end
    end

    assign tmr_rise = timer_ovf & ~tmr_prev_q;
    assign demand   = (update_source_select == SRC_ONDEMAND) && wr.we_high;

    // Trigger selection for the held modes.
    always_comb begin
        fire = 1'b0;
        case (update_source_select)
            SRC_RISE: fire = strb_rise;
            SRC_FALL: fire = strb_fall;
            SRC_BOTH: fire = strb_rise | strb_fall;
            SRC_ONDEMAND: fire = 1'b0;
            default: begin
                if (update_source_select <= SRC_TIMER3) begin
                    fire = tmr_rise[update_source_select[1:0]];
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Input latches. A held-mode trigger takes the bytes as they stood before a
    // write in the same cycle, so a late write waits for the next trigger.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dac_word_q <= WORD_RESET;
        end else if (demand) begin
            dac_word_q <= cdus_compose(wr.data, low_q);
        end else if (fire) begin
            dac_word_q <= cdus_compose(high_q, low_q);
        end
    end

    // Full-scale range; the top range stands from reset.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fs_range_q <= FS_HOT_RESET;
        end else begin
            fs_range_q <= cdus_fs_decode(full_scale_select);
        end
    end

    // Pin takeover and bias; bias is left off while disabled to save current.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_q     <= PIN_RESET;
            bias_en_q <= 1'b0;
        end else begin
            pin_q.gpio_owned <= ~dac_enable;
            pin_q.drv_off    <= dac_enable;
            pin_q.pullup_off <= dac_enable;
            pin_q.analog_on  <= dac_enable;
            bias_en_q        <= dac_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_hold_between;
        (dac_word_q != $past(dac_word_q)) |-> $past(demand || fire);
    endproperty
    a_hold_between: assert property (p_hold_between)
        else $error("DAC word changed without a trigger.");

    property p_ondemand;
        (update_source_select == SRC_ONDEMAND && wr.we_high)
            |=> dac_word_q == {$past(wr.data), $past(low_q[LOW_KEEP_MSB:LOW_KEEP_LSB])};
    endproperty
    a_ondemand: assert property (p_ondemand)
        else $error("High-byte write did not update the word.");

    property p_low_held;
        (update_source_select == SRC_ONDEMAND && wr.we_low && !wr.we_high)
            |=> $stable(dac_word_q);
    endproperty
    a_low_held: assert property (p_low_held)
        else $error("Low-byte write reached the output early.");

    property p_timer_xfer;
        (update_source_select <= SRC_TIMER3 && tmr_rise[update_source_select[1:0]])
            |=> dac_word_q == cdus_compose($past(high_q), $past(low_q));
    endproperty
    a_timer_xfer: assert property (p_timer_xfer)
        else $error("Timer overflow did not transfer held bytes.");

    property p_strobe_xfer;
        ((update_source_select == SRC_RISE && strb_rise)
            || (update_source_select == SRC_FALL && strb_fall)
            || (update_source_select == SRC_BOTH && (strb_rise || strb_fall)))
            |=> dac_word_q == cdus_compose($past(high_q), $past(low_q));
    endproperty
    a_strobe_xfer: assert property (p_strobe_xfer)
        else $error("Strobe edge did not transfer held bytes.");

    property p_once;
        (fire && update_source_select != SRC_ONDEMAND)
            ##1 $stable(update_source_select) |-> !fire;
    endproperty
    a_once: assert property (p_once)
        else $error("Two transfers from one trigger event.");

    property p_enabled;
        dac_enable |=> pin_q.analog_on && pin_q.drv_off && pin_q.pullup_off
            && !pin_q.gpio_owned && bias_en_q;
    endproperty
    a_enabled: assert property (p_enabled)
        else $error("Enabled DAC did not take over the pin.");

    property p_disabled;
        !dac_enable |=> pin_q.gpio_owned && !pin_q.analog_on && !bias_en_q
            && !pin_q.drv_off && !pin_q.pullup_off;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("Disabled DAC still holds the pin.");

    property p_fullscale;
        (full_scale_select == FS_CODE_HALF) |=> fs_range_q == FS_HOT_HALF;
    endproperty
    a_fullscale: assert property (p_fullscale)
        else $error("Full-scale code 00 not decoded to lowest range.");

    property p_fs_one;
        (full_scale_select == FS_CODE_ONE) |=> fs_range_q == FS_HOT_ONE;
    endproperty
    a_fs_one: assert property (p_fs_one)
        else $error("Full-scale code 01 not decoded to middle range.");

    property p_fs_top;
        full_scale_select[1] |=> fs_range_q == FS_HOT_TWO;
    endproperty
    a_fs_top: assert property (p_fs_top)
        else $error("Full-scale code 1x not decoded to top range.");

    // Timers and strobe must not reach the latches while on-demand is selected.
    property p_demand_only;
        (update_source_select == SRC_ONDEMAND && !wr.we_high) |=> $stable(dac_word_q);
    endproperty
    a_demand_only: assert property (p_demand_only)
        else $error("On-demand word moved without a high-byte write.");

    c_ondemand: cover property (demand ##1 demand);
    c_timer: cover property (update_source_select <= SRC_TIMER3 && fire);
    c_both: cover property (update_source_select == SRC_BOTH && strb_fall);
    c_enable: cover property (!dac_enable ##1 dac_enable);
endmodule

// [bench/cdus_update_scheduler_tb.sv]
// Self-checking bench for the current DAC update scheduler.
module cdus_update_scheduler_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cdus_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Design connections and bench state.
    logic       ref_clk;
    logic       rst_n;
    logic       dac_enable;
    logic [2:0] update_source_select;
    logic [1:0] full_scale_select;
    cdus_wr_t   wr;
    logic [3:0] timer_ovf;
    logic       external_convert_strobe;
    logic [9:0] dac_word_q;
    logic [2:0] fs_range_q;
    logic       bias_en_q;
    cdus_pin_t  pin_q;
    logic [9:0] cur;
    logic [7:0] hi;
    logic [7:0] lo;
    int         fail_count = 0;
    int         n_tests    = 0;
    int         cycles     = 0;

    cdus_update_scheduler dut (
        .ref_clk                 (ref_clk),
        .rst_n                   (rst_n),
        .dac_enable              (dac_enable),
        .update_source_select    (update_source_select),
        .full_scale_select       (full_scale_select),
        .wr                      (wr),
        .timer_ovf               (timer_ovf),
        .external_convert_strobe (external_convert_strobe),
        .dac_word_q              (dac_word_q),
        .fs_range_q              (fs_range_q),
        .bias_en_q               (bias_en_q),
        .pin_q                   (pin_q)
    );

    // Free-running 20 MHz system clock.
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // A hung run is cut short well after the few hundred cycles the tests need.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers; every input changes on the falling edge so the design samples settled values.
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // One-cycle write strobe to the high byte (sel=1) or the low byte (sel=0).
    task automatic put(input logic sel, input logic [7:0] d);
        @(negedge ref_clk);
        wr = '{we_high: sel, we_low: ~sel, data: d};
        @(negedge ref_clk);
        wr = '0;
    endtask

    // One-cycle overflow pulse from timer k.
    task automatic pulse(input int k);
        @(negedge ref_clk);
        timer_ovf[k] = 1'b1;
        @(negedge ref_clk);
        timer_ovf[k] = 1'b0;
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        rst_n = 1'b0;
        dac_enable = 1'b0;
        update_source_select = SRC_ONDEMAND;
        full_scale_select = 2'h2;
        wr = '0;
        timer_ovf = 4'h0;
        external_convert_strobe = 1'b0;
        cur = 10'h000;
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_n = 1'b1;
        chk(dac_word_q, 10'h000);
        chk(fs_range_q, 10'h004);
        chk(bias_en_q, 10'h000);
        chk(pin_q, 10'h008);
        // Pin hand-over and bias follow the enable in both directions.
        dac_enable = 1'b1;
        step(2);
        chk(pin_q, 10'h007);
        chk(bias_en_q, 10'h001);
        dac_enable = 1'b0;
        step(2);
        chk(pin_q, 10'h008);
        chk(bias_en_q, 10'h000);
        dac_enable = 1'b1;
        // Every full-scale code, including the 1x alias.
        for (int c = 0; c < 4; c++) begin
            full_scale_select = 2'(c);
            step(2);
            chk(fs_range_q, (c == 0) ? 10'h001 : (c == 1) ? 10'h002 : 10'h004);
        end
        // On-demand: low byte held, high byte write moves the whole word.
        put(1'b0, 8'hC0);
        step(1);
        chk(dac_word_q, 10'h000);
        put(1'b1, 8'hA5);
        step(1);
        chk(dac_word_q, 10'h297);
        put(1'b1, 8'h3C);
        step(1);
        chk(dac_word_q, 10'h0F3);
        pulse(0);
        step(1);
        chk(dac_word_q, 10'h0F3);
        cur = 10'h0F3;
        // Timer modes: only the selected overflow moves the word, once per rising overflow.
        for (int k = 0; k < 4; k++) begin
            update_source_select = 3'(k);
            hi = 8'h10 + 8'(k);
            lo = {2'(k), 6'h15};
            put(1'b0, lo);
            put(1'b1, hi);
            step(1);
            chk(dac_word_q, cur);
            pulse((k + 1) % 4);
            step(1);
            chk(dac_word_q, cur);
            // Overflow and a high write in one cycle: the trigger takes the old byte,
            // and the overflow stays high a second cycle without a second transfer.
            @(negedge ref_clk);
            timer_ovf[k] = 1'b1;
            wr = '{we_high: 1'b1, we_low: 1'b0, data: ~hi};
            @(negedge ref_clk);
            wr = '0;
            step(1);
            timer_ovf[k] = 1'b0;
            cur = {hi, lo[7:6]};
            chk(dac_word_q, cur);
            pulse(k);
            step(1);
            cur = {~hi, lo[7:6]};
            chk(dac_word_q, cur);
        end
        // Strobe modes: rise, fall and both; new data between the two edges.
        for (int m = 4; m < 7; m++) begin
            update_source_select = 3'(m);
            hi = 8'h80 + 8'(m);
            lo = 8'(m) << 6;
            put(1'b0, lo);
            put(1'b1, hi);
            step(8);
            chk(dac_word_q, cur);
            external_convert_strobe = 1'b1;
            step(8);
            if (m != 5) begin
                cur = {hi, lo[7:6]};
            end
            chk(dac_word_q, cur);
            put(1'b1, ~hi);
            step(8);
            chk(dac_word_q, cur);
            external_convert_strobe = 1'b0;
            step(8);
            if (m != 4) begin
                cur = {~hi, lo[7:6]};
            end
            chk(dac_word_q, cur);
        end
        end_sim();
    end

endmodule
